/* File: verilog/mad_pkg.sv */
// Package: microword field layout, codes, timing and register map of the ALU datapath
package mad_pkg;
	// Microword layout
	localparam int MW_W = 38;
	localparam int FN_LO = 29;         // Function select 31:29
	localparam int SRC_LO = 26;        // Source select 28:26
	localparam int DST_LO = 32;        // Destination select 34:32
	localparam int AADR_LO = 8;        // A address 11:8
	localparam int BADR_LO = 12;       // B address 15:12
	localparam int CCU_HI = 33;        // Condition update 33:32
	localparam int CCU_LO = 32;
	localparam int ROT_BIT = 35;       // Rotate instead of shift
	localparam int DP_BIT = 36;        // Double precision
	localparam int CIN_BIT = 37;       // Carry-in to the low slice
	localparam int RDTYPE_BIT = 7;     // Low means local store read
	localparam int DERSEL_BIT = 5;
	localparam int DER_HI = 33;        // Discrete read needs 33:31 all set
	localparam int DER_LO = 31;
	// Function codes
	localparam logic [2:0] FN_ADD = 3'h0;
	localparam logic [2:0] FN_SUBR = 3'h1;
	localparam logic [2:0] FN_SUBS = 3'h2;
	localparam logic [2:0] FN_OR = 3'h3;
	localparam logic [2:0] FN_AND = 3'h4;
	localparam logic [2:0] FN_NOTRS = 3'h5;
	localparam logic [2:0] FN_XOR = 3'h6;
	localparam logic [2:0] FN_XNOR = 3'h7;
	// Destination codes
	localparam logic [2:0] DST_QREG = 3'h0;
	localparam logic [2:0] DST_NONE = 3'h1;
	localparam logic [2:0] DST_RAMA = 3'h2;
	localparam logic [2:0] DST_RAMF = 3'h3;
	// Timing: one microcycle of two clock phases
	localparam int CLK_MHZ = 10;
	localparam int CYCLE_NS = 200;
	localparam int CYCLE_CLKS = CYCLE_NS * CLK_MHZ / 1000;
	// Register map
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic CTRL_RST = 1'b1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: verilog/mad_alu_datapath.sv */
// Eight-bit microcoded ALU datapath with register file, Q register and register bus
module mad_alu_datapath (
	// Clock, reset, enable
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sys_ce,
	// Microword and bus operand
	input wire logic [mad_pkg::MW_W-1:0] microwordFields,
	input wire logic [7:0] externalBusOperand,
	// Internal bus driver
	output logic [7:0] busOut,
	output logic busOe,
	output logic latePhase,
	// Shift end lines, value and enable
	output logic regfileShiftTopLine,
	output logic regfileShiftTopOe,
	output logic regfileShiftBottomLine,
	output logic regfileShiftBottomOe,
	output logic qregShiftTopLine,
	output logic qregShiftTopOe,
	output logic qregShiftBottomLine,
	output logic qregShiftBottomOe,
	// Condition codes
	output logic resultZeroFlag,
	output logic resultSignFlag,
	output logic resultCarryFlag,
	output logic resultOverflowFlag,
	output logic auxZeroFlag,
	// AXI4-Lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import mad_pkg::*;

	logic [7:0] regFile [16];
	logic [7:0] aLat, bLat, qReg, aRd, aOp, bOp, rOp, sOp, xIn, yIn, aluF, ramIn, qIn;
	logic [2:0] fn, src, dst, mode;
	logic [3:0] aAdr, bAdr;
	logic [2:0] cy;
	logic c7, cinAlu, arith, stepOn, runEn, shiftDst, ramWr, qWr, rdCycle, ccUpd;
	logic ramTop, ramBot, qTop, qBot;
	logic [31:0] statWord;

	// Field decode
	assign fn = microwordFields[FN_LO+:3];
	assign src = microwordFields[SRC_LO+:3];
	assign dst = microwordFields[DST_LO+:3];
	assign aAdr = microwordFields[AADR_LO+:4];
	assign bAdr = microwordFields[BADR_LO+:4];
	assign mode = {dst[1], microwordFields[ROT_BIT], microwordFields[DP_BIT]};
	assign ccUpd = &microwordFields[CCU_HI:CCU_LO];
	assign shiftDst = dst[2];
	assign ramWr = (dst != DST_QREG) && (dst != DST_NONE);
	assign qWr = (dst == DST_QREG) || (shiftDst && !dst[0]);
	assign rdCycle = (&microwordFields[DER_HI:DER_LO] && microwordFields[RDTYPE_BIT]
		&& microwordFields[DERSEL_BIT]) || !microwordFields[RDTYPE_BIT];
	assign stepOn = sys_ce && runEn;

	// Both file outputs read the same array, so equal addresses show one word
	assign aRd = regFile[aAdr];
	assign aOp = latePhase ? aLat : aRd;
	assign bOp = latePhase ? bLat : regFile[bAdr];

	// Operand muxes, zero is the inhibit state
	always_comb begin
		case (src)
			3'h0: begin rOp = aOp; sOp = 8'h00; end
			3'h1: begin rOp = aOp; sOp = bOp; end
			3'h2: begin rOp = 8'h00; sOp = qReg; end
			3'h3: begin rOp = 8'h00; sOp = bOp; end
			3'h4: begin rOp = 8'h00; sOp = aOp; end
			3'h5: begin rOp = externalBusOperand; sOp = aOp; end
			3'h6: begin rOp = externalBusOperand; sOp = qReg; end
			default: begin rOp = externalBusOperand; sOp = 8'h00; end
		endcase
	end

	// Subtraction as complement-add; carry-in forced low for logic
	always_comb begin
		arith = 1'b1;
		xIn = rOp;
		yIn = sOp;
		cinAlu = microwordFields[CIN_BIT];
		case (fn)
			FN_ADD: ;
			FN_SUBR: begin xIn = sOp; yIn = ~rOp; cinAlu = !microwordFields[CIN_BIT]; end
			FN_SUBS: begin yIn = ~sOp; cinAlu = !microwordFields[CIN_BIT]; end
			default: begin arith = 1'b0; cinAlu = 1'b0; end
		endcase
	end
	assign cy[0] = cinAlu;

	// Two four-bit slices with the carry chained between them
	logic [7:0] sumF;
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gSlice
			assign {cy[g+1], sumF[g*4+:4]} = {1'b0, xIn[g*4+:4]} + {1'b0, yIn[g*4+:4]} + {4'h0, cy[g]};
		end
	endgenerate
	assign c7 = xIn[7] ^ yIn[7] ^ sumF[7];

	always_comb begin
		case (fn)
			FN_OR: aluF = rOp | sOp;
			FN_AND: aluF = rOp & sOp;
			FN_NOTRS: aluF = ~rOp & sOp;
			FN_XOR: aluF = rOp ^ sOp;
			FN_XNOR: aluF = ~(rOp ^ sOp);
			default: aluF = sumF;
		endcase
	end

	// End bits per mode {up, rotate, double}
	always_comb begin
		ramTop = 1'b0;
		ramBot = 1'b0;
		qTop = 1'b0;
		qBot = 1'b0;
		case (mode)
			3'h0: ;
			3'h1: qTop = aluF[0];
			3'h2: begin ramTop = aluF[0]; qTop = qReg[0]; end
			3'h3: begin ramTop = qReg[0]; qTop = aluF[0]; end
			3'h4: ;
			3'h5: ramBot = qReg[7];
			3'h6: begin ramBot = aluF[7]; qBot = qReg[7]; end
			default: begin ramBot = qReg[7]; qBot = aluF[7]; end
		endcase
	end

	// Shifters: up moves toward the MSB, non-shift passes through
	always_comb begin
		if (!shiftDst) begin
			ramIn = aluF;
			qIn = aluF;
		end else if (mode[2]) begin
			ramIn = {aluF[6:0], ramBot};
			qIn = {qReg[6:0], qBot};
		end else begin
			ramIn = {ramTop, aluF[7:1]};
			qIn = {qTop, qReg[7:1]};
		end
	end

	// Phase counter: early then late half of each microcycle
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			latePhase <= 1'b0;
		else if (stepOn)
			latePhase <= !latePhase;
	end

	// A/B latches follow the file in the early phase, hold in the late one
	always_ff @(posedge sys_clk) begin
		if (stepOn && !latePhase) begin
			aLat <= aRd;
			bLat <= regFile[bAdr];
		end
	end

	// File and Q are not reset; microcode must initialise them
	always_ff @(posedge sys_clk) begin
		if (stepOn && latePhase && ramWr)
			regFile[bAdr] <= ramIn;
	end

	always_ff @(posedge sys_clk) begin
		if (stepOn && latePhase && qWr)
			qReg <= (dst == DST_QREG) ? aluF : qIn;
	end

	// Flags: main set only on request, auxiliary zero every cycle
	always_ff @(posedge sys_clk) begin
		if (stepOn && latePhase) begin
			auxZeroFlag <= (aluF == 8'h00);
			if (ccUpd) begin
				resultZeroFlag <= (aluF == 8'h00);
				resultSignFlag <= aluF[7];
				resultCarryFlag <= arith && cy[2];
				resultOverflowFlag <= arith && (cy[2] ^ c7);
			end
		end
	end

	// Bus driver: launched for the late phase only, never on read cycles
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			busOe <= 1'b0;
			busOut <= 8'h00;
		end else if (stepOn) begin
			busOe <= !latePhase && !rdCycle;
			busOut <= (dst == DST_RAMA) ? aRd : aluF;
		end
	end

	// End lines: enabled only while the destination shifts
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			regfileShiftTopOe <= 1'b0;
			regfileShiftBottomOe <= 1'b0;
			qregShiftTopOe <= 1'b0;
			qregShiftBottomOe <= 1'b0;
			regfileShiftTopLine <= 1'b0;
			regfileShiftBottomLine <= 1'b0;
			qregShiftTopLine <= 1'b0;
			qregShiftBottomLine <= 1'b0;
		end else if (sys_ce) begin
			regfileShiftTopOe <= shiftDst;
			regfileShiftBottomOe <= shiftDst;
			qregShiftTopOe <= shiftDst;
			qregShiftBottomOe <= shiftDst;
			regfileShiftTopLine <= mode[2] ? aluF[7] : ramTop;
			regfileShiftBottomLine <= mode[2] ? ramBot : aluF[0];
			qregShiftTopLine <= mode[2] ? qReg[7] : qTop;
			qregShiftBottomLine <= mode[2] ? qBot : qReg[0];
		end
	end

	// AXI4-Lite write: address and data taken together, one at a time
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			runEn <= CTRL_RST;
		end else if (sys_ce) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (s_axi_awaddr == ADDR_CTRL) ? RESP_OKAY : RESP_SLVERR;
				if (s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0])
					runEn <= s_axi_wdata[0];
			end
		end
	end

	// Status word: flags, phase and Q contents
	assign statWord = {16'h0000, qReg, 2'h0, latePhase, auxZeroFlag,
		resultZeroFlag, resultSignFlag, resultCarryFlag, resultOverflowFlag};

	// AXI4-Lite read; unmapped addresses answer SLVERR with zero data
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (sys_ce) begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				case (s_axi_araddr)
					ADDR_CTRL: s_axi_rdata <= {31'h00000000, runEn};
					ADDR_STAT: s_axi_rdata <= statWord;
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end
		end
	end

	// Checks
	busoff_early_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		busOe |-> latePhase) else $error("bus driven in first phase");
	busoff_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && rdCycle) |=> !busOe) else $error("bus driven on read cycle");
	bus_asel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && !latePhase && dst == DST_RAMA) |=> busOut == aLat) else $error("bus not A output");
	qload_alu_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase && dst == DST_QREG) |=> qReg == $past(aluF)) else $error("Q not loaded");
	qhold_none_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase && dst == DST_NONE) |=> $stable(qReg)) else $error("Q changed on none");
	cc_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase && !ccUpd) |=> $stable({resultZeroFlag, resultSignFlag,
		resultCarryFlag, resultOverflowFlag})) else $error("codes changed without request");
	cc_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase && ccUpd) |=> resultZeroFlag == ($past(aluF) == 8'h00)
		&& resultSignFlag == $past(aluF[7])) else $error("zero or sign wrong");
	aux_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase) |=> auxZeroFlag == ($past(aluF) == 8'h00)) else $error("aux zero wrong");
	qend_hiz_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(sys_ce && !shiftDst) |=> !qregShiftTopOe && !qregShiftBottomOe) else $error("Q end driven");
	shift_up_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(stepOn && latePhase && dst == 3'h7) |=> regFile[$past(bAdr)][7:1] == $past(aluF[6:0]))
		else $error("up shift wrong");
	phase_alt_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		stepOn |=> latePhase != $past(latePhase)) else $error("phase stuck");

	add_carry_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		stepOn && latePhase && fn == FN_ADD && ccUpd && cy[2]);
	shift_wr_c: cover property (@(posedge sys_clk) disable iff (sys_rst)
		stepOn && latePhase && shiftDst && mode[0]);
	bus_drive_c: cover property (@(posedge sys_clk) disable iff (sys_rst) busOe ##1 !busOe);
	axi_write_c: cover property (@(posedge sys_clk) disable iff (sys_rst) s_axi_bvalid && s_axi_bready);
endmodule

/* File: testbench/mad_useq_model.sv */
// Microword register and sequencer model that feeds the datapath one word per microcycle, and one per clock while runEn holds it in the late phase
module mad_useq_model (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic sys_ce,
	// Phase seen from the datapath
	input wire logic latePhase,
	// Word offered by the bench
	input wire logic [mad_pkg::MW_W-1:0] wordIn,
	input wire logic wordValid,
	output logic wordReady,
	// Microword register
	output logic [mad_pkg::MW_W-1:0] microwordFields
);
	timeunit 1ns;
	timeprecision 1ns;
	import mad_pkg::*;
	// Idle word: pass the bus operand, write nothing, no main flag update
	localparam logic [MW_W-1:0] IDLE_WORD = 38'h011C000080;
	// Swap words only at a late edge, so a word holds through its microcycle except while runEn holds the datapath in the late phase
	assign wordReady = sys_ce & latePhase;
	// Starved sequencer issues idle words rather than repeating the last one
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			microwordFields <= IDLE_WORD;
		end else if (wordReady) begin
			microwordFields <= wordValid ? wordIn : IDLE_WORD;
		end
	end
endmodule

/* File: testbench/microengine_alu_datapath_bench.sv */
// Self-checking bench for the microcoded ALU datapath
module microengine_alu_datapath_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import mad_pkg::*;
	typedef struct packed {logic [MW_W-1:0] w; logic [7:0] ext; logic [7:0] bus; logic [4:0] fl; logic [3:0] ln;} mad_row_t;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic sys_ce = 1'b1;
	logic [MW_W-1:0] microwordFields, wordIn = '0;
	logic wordValid = 1'b0, wordReady;
	logic [7:0] externalBusOperand = 8'h00, busOut;
	logic busOe, latePhase, auxZeroFlag, resultZeroFlag, resultSignFlag, resultCarryFlag, resultOverflowFlag;
	logic regfileShiftTopLine, regfileShiftTopOe, regfileShiftBottomLine, regfileShiftBottomOe;
	logic qregShiftTopLine, qregShiftTopOe, qregShiftBottomLine, qregShiftBottomOe;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int errorCnt = 0;
	int nCompared = 0;
	mad_row_t rows[$];
	wire anyOe = |{regfileShiftTopOe, regfileShiftBottomOe, qregShiftTopOe, qregShiftBottomOe};

	mad_alu_datapath DUT (.*);
	mad_useq_model SEQ (.*);

	// Free-running 10 MHz clock
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic stopTest;
		if (errorCnt == 0 && nCompared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [39:0] g, input logic [39:0] e);
		nCompared++;
		if (g !== e) begin
			errorCnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Word layout: carry-in, precision, rotate, dest, function, source, B, A, plain cycle
	// Mode m: bit 0 carry-in, bit 1 rotate, bit 2 double precision
	function automatic logic [MW_W-1:0] mw(input logic [2:0] f, s, d, input logic [3:0] a, b, input logic [2:0] m);
		return {m[0], m[2], m[1], d, f, s, 10'h000, b, a, 8'h80};
	endfunction

	// End lines ln: file top, file bottom, Q top, Q bottom; looked at only on shifting rows
	task automatic r(input logic [2:0] f, s, d, input logic [3:0] a, b, input logic [7:0] x, e,
		input logic [4:0] fl, input logic [2:0] m = 3'h0, input logic [3:0] ln = 4'h0);
		rows.push_back('{mw(f, s, d, a, b, m), x, e, fl, ln});
	endtask

	// One microcycle: offer the word, then check both phases and the flags it leaves
	task automatic exec(input mad_row_t t);
		logic oe;
		oe = t.w[7] & ~(&{t.w[33:31], t.w[5]});
		wordIn <= t.w;
		wordValid <= 1'b1;
		externalBusOperand <= t.ext;
		// Sequencer takes the word only at a late edge; the watchdog ends a stall
		do begin
			@(posedge sys_clk);
		end while (wordReady !== 1'b1);
		wordValid <= 1'b0;
		@(posedge sys_clk);
		chk(busOe, 1'b0);
		@(posedge sys_clk);
		chk({latePhase, busOe}, {1'b1, oe});
		if (oe) chk(busOut, t.bus);
		chk(anyOe, t.w[34]);
		if (t.w[34]) chk({regfileShiftTopLine, regfileShiftBottomLine, qregShiftTopLine, qregShiftBottomLine}, t.ln);
		@(posedge sys_clk);
		chk({auxZeroFlag, resultZeroFlag, resultSignFlag, resultCarryFlag, resultOverflowFlag}, t.fl);
	endtask

	// Phase must not move while stalled; an odd count catches a free-running toggle
	task automatic frozen;
		logic lp;
		@(posedge sys_clk);
		lp = latePhase;
		repeat (3) @(posedge sys_clk);
		chk(latePhase, lp);
	endtask

	// No cycle count assumed: only the watchdog ends a wait for the answer
	task automatic axw(input logic [3:0] ad, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
		@(posedge sys_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		chk(s_axi_bresp, er);
	endtask

	task automatic axr(input logic [3:0] ad, input logic [1:0] er, input logic [31:0] ed, input logic [31:0] mk = '1);
		@(posedge sys_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		chk({s_axi_rresp, s_axi_rdata & mk}, {er, ed});
	endtask

	// About 200 cycles expected; cut off at 20000
	initial begin
		#2000000;
		errorCnt++;
		stopTest();
	end

	initial begin
		// Loads of r1, r2 and Q, then every source code
		r(3'h0,3'h7,3'h3,4'h0,4'h1,8'h5A,8'h5A,5'h00);
		r(3'h0,3'h7,3'h3,4'h0,4'h2,8'h81,8'h81,5'h04);
		r(3'h0,3'h7,3'h0,4'h0,4'h0,8'hC3,8'hC3,5'h04);
		r(3'h2,3'h0,3'h1,4'h1,4'h0,8'h00,8'h5A,5'h04);
		r(3'h0,3'h1,3'h1,4'h1,4'h2,8'h00,8'hDB,5'h04);
		r(3'h0,3'h2,3'h1,4'h0,4'h0,8'h00,8'hC3,5'h04);
		r(3'h0,3'h3,3'h1,4'h0,4'h2,8'h00,8'h81,5'h04);
		r(3'h2,3'h4,3'h1,4'h1,4'h0,8'h00,8'hA6,5'h04);
		r(3'h0,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h96,5'h05);
		r(3'h6,3'h6,3'h3,4'h0,4'hF,8'h3C,8'hFF,5'h04);
		r(3'h0,3'h7,3'h3,4'h0,4'hF,8'h00,8'h00,5'h18);
		// Remaining functions on R=bus, S=r1
		r(3'h1,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h1E,5'h02);
		r(3'h2,3'h5,3'h3,4'h1,4'hF,8'h3C,8'hE2,5'h04);
		r(3'h3,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h7E,5'h00);
		r(3'h4,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h18,5'h00);
		r(3'h5,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h42,5'h00);
		r(3'h7,3'h5,3'h3,4'h1,4'hF,8'h3C,8'h99,5'h04);
		r(3'h0,3'h5,3'h3,4'h1,4'hF,8'hFF,8'h5A,5'h02,2'h1);
		// Bus shows A on code 010, same-address read, aux-only zero
		r(3'h0,3'h7,3'h2,4'h1,4'hF,8'h77,8'h5A,5'h02);
		r(3'h0,3'h3,3'h1,4'h0,4'hF,8'h00,8'h77,5'h02);
		r(3'h0,3'h1,3'h1,4'h2,4'h2,8'h00,8'h02,5'h02);
		r(3'h0,3'h7,3'h1,4'h0,4'h0,8'h00,8'h00,5'h12);
		// Shifts, rotate and Q shift, each read back
		r(3'h0,3'h7,3'h5,4'h0,4'hE,8'h5A,8'h5A,5'h02,3'h0,4'h1);
		r(3'h0,3'h3,3'h1,4'h0,4'hE,8'h00,8'h2D,5'h02);
		r(3'h0,3'h7,3'h7,4'h0,4'hE,8'h5A,8'h5A,5'h00,3'h0,4'h2);
		r(3'h0,3'h3,3'h1,4'h0,4'hE,8'h00,8'hB4,5'h00);
		r(3'h0,3'h7,3'h7,4'h0,4'hE,8'h81,8'h81,5'h04,3'h2,4'hF);
		r(3'h0,3'h3,3'h1,4'h0,4'hE,8'h00,8'h03,5'h04);
		r(3'h0,3'h7,3'h4,4'h0,4'hD,8'h00,8'h00,5'h14,3'h0,4'h1);
		r(3'h0,3'h2,3'h1,4'h0,4'h0,8'h00,8'h61,5'h04);
		// Double precision: rotate up with Q, then shift down with Q, each read back
		r(3'h0,3'h7,3'h6,4'h0,4'hC,8'hA5,8'hA5,5'h04,3'h6,4'h9);
		r(3'h0,3'h3,3'h1,4'h0,4'hC,8'h00,8'h4A,5'h04);
		r(3'h0,3'h2,3'h1,4'h0,4'h0,8'h00,8'hC3,5'h04);
		r(3'h0,3'h7,3'h4,4'h0,4'hB,8'h01,8'h01,5'h04,3'h4,4'h7);
		r(3'h0,3'h2,3'h1,4'h0,4'h0,8'h00,8'hE1,5'h04);
		repeat (12) @(posedge sys_clk);
		chk({busOe, latePhase, anyOe, s_axi_bvalid, s_axi_rvalid}, 5'h00);
		sys_rst <= 1'b0;
		foreach (rows[i]) exec(rows[i]);
		// Local store read, then discrete register read
		exec('{mw(3'h0,3'h7,3'h1,4'h0,4'h0,3'h0) & ~38'h80, 8'h00, 8'h00, 5'h14, 4'h0});
		exec('{mw(3'h4,3'h7,3'h3,4'h0,4'h0,3'h0) | 38'h20, 8'h00, 8'h00, 5'h18, 4'h0});
		// Clock enable low holds everything
		sys_ce <= 1'b0;
		frozen();
		sys_ce <= 1'b1;
		axr(ADDR_CTRL, RESP_OKAY, 32'h1);
		axr(ADDR_STAT, RESP_OKAY, 32'hE118, ~32'h20);
		axw(ADDR_STAT, 32'h0, 4'hF, RESP_SLVERR);
		axr(4'h8, RESP_SLVERR, 32'h0);
		axw(ADDR_CTRL, 32'h0, 4'h0, RESP_OKAY);
		axr(ADDR_CTRL, RESP_OKAY, 32'h1);
		axw(ADDR_CTRL, 32'h0, 4'hF, RESP_OKAY);
		frozen();
		// Mid-run reset while stalled must bring the run enable back
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({busOe, latePhase, anyOe, s_axi_bvalid, s_axi_rvalid}, 5'h00);
		sys_rst <= 1'b0;
		axr(ADDR_CTRL, RESP_OKAY, 32'h1);
		exec(rows[0]);
		axw(ADDR_CTRL, 32'h1, 4'hF, RESP_OKAY);
		stopTest();
	end
endmodule
